//--- pkg/spibf_pkg.sv
// spi baud-rate and status-flag block: shared constants
// assumes a 32-bit apb register port; registers sit at byte address 4*index
package spibf_pkg;

  // ---------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL1   = 4'h0;  // first control register
  localparam logic [3:0] IDX_CTRL2   = 4'h1;  // serial_control_two
  localparam logic [3:0] IDX_BAUD    = 4'h2;  // prescale and rate fields
  localparam logic [3:0] IDX_STATUS  = 4'h3;  // serial_flag_status
  localparam logic [3:0] IDX_DATA    = 4'h5;  // serial_data_reg
  localparam logic [3:0] IDX_IRQ_ST  = 4'h6;  // sticky event status
  localparam logic [3:0] IDX_IRQ_EN  = 4'h7;  // event enable
  localparam logic [3:0] IDX_IRQ_CLR = 4'h8;  // write-one-to-clear events

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int C1_EN_BIT   = 6;  // block enable
  localparam int C1_MSTR_BIT = 4;  // master when set
  localparam int C2_MFEN_BIT = 4;  // master_fault_detect_en
  localparam int ST_RXF_BIT  = 7;  // rx_complete_flag
  localparam int ST_TXE_BIT  = 5;  // tx_empty_flag
  localparam int ST_MF_BIT   = 4;  // master_fault_flag
  localparam int BAUD_PRE_LO = 4;  // baud_prescale_bit0 position
  localparam int BAUD_RATE_LO = 0; // baud_rate_bit0 position
  localparam int EV_RX = 0;        // event bit: byte received
  localparam int EV_TX = 1;        // event bit: tx register emptied
  localparam int EV_MF = 2;        // event bit: mode fault

  // ---------------------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [6:0] BAUD_RST  = 7'h00;
  localparam logic [2:0] IRQ_RST   = 3'h0;
  localparam logic [3:0] BITS_LAST = 4'h7;   // last bit index of a byte
  localparam int         DIV_W     = 11;     // half-period counter width

endpackage

//--- verilog/spibf_baud_div.sv
// spi baud-rate half-period tick generator
// assumes prescale/rate are stable while run_in is high
`timescale 1ns/1ps
module spibf_baud_div
  import spibf_pkg::*;
(
  input  wire logic       clock_in,     // bus clock
  input  wire logic       resetn_in,    // async reset, active low
  input  wire logic       run_in,       // count while high
  input  wire logic [2:0] prescale_in,  // prescale field
  input  wire logic [2:0] rate_in,      // rate field
  output logic            tick_out      // one pulse per serial half period
);

  // ---------------------------------------------------------------------------
  // half period = (prescale+1) * 2^rate, full divisor twice that
  // ---------------------------------------------------------------------------
  logic [3:0]       pre_plus;  // prescale + 1
  logic [DIV_W-1:0] half;      // half period in bus clocks
  logic [DIV_W-1:0] cnt_q;     // running count

  assign pre_plus = {1'b0, prescale_in} + 4'h1;
  assign half     = {7'h00, pre_plus} << rate_in;

  // count up and pulse at the end of each half period
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin  // idle: restart cleanly
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else if (cnt_q == half - 11'h001) begin
      cnt_q    <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 11'h001;
      tick_out <= 1'b0;
    end
  end

  // helper: bus clocks since the last tick during one run
  logic [DIV_W-1:0] gap_q;   // cycles since last tick
  logic             seen_q;  // a tick happened in this run
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else if (!run_in) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else if (tick_out) begin
      gap_q  <= 11'h001;
      seen_q <= 1'b1;
    end else begin
      gap_q  <= gap_q + 11'h001;
    end
  end

  a_baud_half_gap: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (run_in && $stable(run_in) && seen_q && tick_out) |-> (gap_q == half))
    else $error("serial half period does not match baud fields");

endmodule

//--- verilog/spibf_top.sv
// spi baud division, status flags and a minimal byte shifter behind apb
// assumes link pins are asynchronous; mode is clock idle low, sample on rise
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module spibf_top
  import spibf_pkg::*;
(
  input  wire logic        clock_in,     // bus clock, 125 mhz
  input  wire logic        resetn_in,    // async reset, active low
  input  wire logic        psel_in,      // apb select
  input  wire logic        penable_in,   // apb access phase
  input  wire logic        pwrite_in,    // apb write when high
  input  wire logic [11:0] paddr_in,     // apb byte address
  input  wire logic [31:0] pwdata_in,    // apb write data
  output logic [31:0]      prdata_out,   // apb read data
  output logic             pready_out,   // apb ready
  output logic             pslverr_out,  // apb error on unmapped address
  input  wire logic        sclk_in,      // serial clock from a master
  output logic             sclk_out,     // serial clock as master
  output logic             sclk_oe_out,  // drive serial clock
  input  wire logic        mosi_in,      // data line in (slave)
  output logic             mosi_out,     // data line out (master)
  output logic             mosi_oe_out,  // drive mosi
  input  wire logic        miso_in,      // data line in (master)
  output logic             miso_out,     // data line out (slave)
  output logic             miso_oe_out,  // drive miso
  input  wire logic        ss_n_in,      // slave select, active low
  output logic             irq_out       // level interrupt
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic ss_s1_q, ss_s2_q, ss_s3_q;     // select sync plus edge stage
  logic sck_s1_q, sck_s2_q, sck_s3_q;  // serial clock sync plus edge stage
  logic mosi_s1_q, mosi_s2_q;          // mosi sync
  logic miso_s1_q, miso_s2_q;          // miso sync

  // two flops per pin, a third on select and serial clock; stages two and three feed logic
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {ss_s1_q, ss_s2_q, ss_s3_q}    <= 3'h7;
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {mosi_s1_q, mosi_s2_q}         <= 2'h0;
      {miso_s1_q, miso_s2_q}         <= 2'h0;
    end else begin
      {ss_s1_q, ss_s2_q, ss_s3_q}    <= {ss_n_in, ss_s1_q, ss_s2_q};
      {sck_s1_q, sck_s2_q, sck_s3_q} <= {sclk_in, sck_s1_q, sck_s2_q};
      {mosi_s1_q, mosi_s2_q}         <= {mosi_in, mosi_s1_q};
      {miso_s1_q, miso_s2_q}         <= {miso_in, miso_s1_q};
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave: one wait-free access phase, answer registered at setup
  // ---------------------------------------------------------------------------
  logic [3:0] idx;       // register index
  logic       mapped;    // address hits a register
  logic       setup;     // setup phase
  logic       xfer;      // access completes this edge
  logic       st_rd;     // status read completes
  logic       data_rd;   // data read completes
  logic       data_wr;   // data write completes
  logic       c1_wr;     // control-one write completes
  logic [7:0] rd_mux;    // read value
  logic [7:0] ctrl1_q;   // control one
  logic [7:0] ctrl2_q;   // control two
  logic [6:0] baud_q;    // {prescale, 0, rate}
  logic [2:0] irq_st_q;  // sticky events
  logic [2:0] irq_en_q;  // event enables
  logic       rxf_q;     // rx_complete_flag
  logic       txe_q;     // tx_empty_flag
  logic       mf_q;      // master_fault_flag
  logic [7:0] rx_data_q; // received byte
  logic [7:0] tx_buf_q;  // byte waiting to be sent

  assign idx     = paddr_in[5:2];
  assign mapped  = (paddr_in[11:6] == 6'h00) && (paddr_in[1:0] == 2'h0) &&
                   (idx <= IDX_IRQ_CLR) && (idx != 4'h4);
  assign setup   = psel_in && !penable_in;
  assign xfer    = psel_in && penable_in && pready_out;
  assign st_rd   = xfer && !pwrite_in && (idx == IDX_STATUS);
  assign data_rd = xfer && !pwrite_in && (idx == IDX_DATA);
  assign data_wr = xfer && pwrite_in && (idx == IDX_DATA);
  assign c1_wr   = xfer && pwrite_in && (idx == IDX_CTRL1);

  // read multiplexer; the status register is readable at any time
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_CTRL1:  rd_mux = ctrl1_q;
      IDX_CTRL2:  rd_mux = ctrl2_q;
      IDX_BAUD:   rd_mux = {1'b0, baud_q};
      IDX_STATUS: rd_mux = {rxf_q, 1'b0, txe_q, mf_q, 4'h0};
      IDX_DATA:   rd_mux = rx_data_q;
      IDX_IRQ_ST: rd_mux = {5'h00, irq_st_q};
      IDX_IRQ_EN: rd_mux = {5'h00, irq_en_q};
      default:    rd_mux = 8'h00;  // clear register and holes read zero
    endcase
  end

  // answer: ready in the first access cycle, data captured at setup
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped;
      if (setup) begin
        prdata_out <= (mapped && !pwrite_in) ? {24'h000000, rd_mux} : 32'h0;
      end
    end
  end

  // software-written configuration; status writes change nothing
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl1_q  <= CTRL1_RST;
      ctrl2_q  <= CTRL2_RST;
      baud_q   <= BAUD_RST;
      irq_en_q <= IRQ_RST;
    end else if (xfer && pwrite_in && mapped) begin
      unique case (idx)
        IDX_CTRL1:  ctrl1_q  <= pwdata_in[7:0];
        IDX_CTRL2:  ctrl2_q  <= pwdata_in[7:0];
        IDX_BAUD:   baud_q   <= pwdata_in[6:0];
        IDX_IRQ_EN: irq_en_q <= pwdata_in[2:0];
        default:    ;  // status, data and clear handled elsewhere
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // clear-by-sequence arming
  // ---------------------------------------------------------------------------
  logic rx_arm_q;  // status seen with rx flag set
  logic tx_arm_q;  // status seen with tx flag set
  logic mf_arm_q;  // status seen with fault flag set

  // armed by a status read, disarmed only by its own follow-up access
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_arm_q <= 1'b0;
      tx_arm_q <= 1'b0;
      mf_arm_q <= 1'b0;
    end else begin
      if (st_rd && prdata_out[ST_RXF_BIT]) rx_arm_q <= 1'b1;
      else if (data_rd) rx_arm_q <= 1'b0;
      if (st_rd && prdata_out[ST_TXE_BIT]) tx_arm_q <= 1'b1;
      else if (data_wr) tx_arm_q <= 1'b0;
      if (st_rd && prdata_out[ST_MF_BIT]) mf_arm_q <= 1'b1;
      else if (c1_wr) mf_arm_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // byte shifter
  // ---------------------------------------------------------------------------
  typedef enum logic {SH_IDLE, SH_RUN} spibf_sh_t;
  spibf_sh_t  sh_q;       // shifter state
  logic [7:0] shift_q;    // outgoing / incoming bits
  logic [3:0] bit_q;      // bits done
  logic       rx_bit_q;   // bit sampled on the rising edge
  logic       sck_q;      // master serial clock level
  logic       tick;       // half-period pulse
  logic       master;     // master mode
  logic       enabled;    // block enabled
  logic       load;       // shifter takes the buffer
  logic       rx_done;    // byte complete
  logic       rise_ev;    // sample point
  logic       fall_ev;    // shift point
  logic       mf_event;   // mode fault detected
  logic       accept;     // data write accepted

  assign master   = ctrl1_q[C1_MSTR_BIT];
  assign enabled  = ctrl1_q[C1_EN_BIT];
  assign load     = enabled && (sh_q == SH_IDLE) && !txe_q;
  assign rise_ev  = master ? (tick && !sck_q) : (sck_s2_q && !sck_s3_q && !ss_s2_q);
  assign fall_ev  = master ? (tick && sck_q) : (!sck_s2_q && sck_s3_q && !ss_s2_q);
  assign rx_done  = (sh_q == SH_RUN) && fall_ev && (bit_q == BITS_LAST);
  assign mf_event = enabled && master && ctrl2_q[C2_MFEN_BIT] &&
                    ss_s3_q && !ss_s2_q;
  assign accept   = data_wr && tx_arm_q;

  spibf_baud_div u_div (
    .clock_in    (clock_in),
    .resetn_in   (resetn_in),
    .run_in      ((sh_q == SH_RUN) && master),
    .prescale_in (baud_q[BAUD_PRE_LO +: 3]),
    .rate_in     (baud_q[BAUD_RATE_LO +: 3]),
    .tick_out    (tick)
  );

  // eight bits msb first, sample on rise, shift on fall; miso sync lag needs half >= 4
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_q     <= SH_IDLE;
      shift_q  <= 8'h00;
      bit_q    <= 4'h0;
      rx_bit_q <= 1'b0;
      sck_q    <= 1'b0;
    end else begin
      unique case (sh_q)
        SH_IDLE: begin
          sck_q <= 1'b0;
          if (load) begin  // start with the buffered byte
            shift_q <= tx_buf_q;
            bit_q   <= 4'h0;
            sh_q    <= SH_RUN;
          end
        end
        SH_RUN: begin
          if (!enabled || mf_event) begin  // abort on disable or fault
            sh_q  <= SH_IDLE;
            sck_q <= 1'b0;
          end else if (rise_ev) begin
            rx_bit_q <= master ? miso_s2_q : mosi_s2_q;
            if (master) sck_q <= 1'b1;
          end else if (fall_ev) begin
            shift_q <= {shift_q[6:0], rx_bit_q};
            bit_q   <= bit_q + 4'h1;
            if (master) sck_q <= 1'b0;
            if (bit_q == BITS_LAST) sh_q <= SH_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // data registers and status flags; a setting event beats a clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_data_q <= 8'h00;
      tx_buf_q  <= 8'h00;
    end else begin
      if (rx_done) rx_data_q <= {shift_q[6:0], rx_bit_q};
      if (accept) tx_buf_q <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxf_q <= 1'b0;
      txe_q <= 1'b1;
      mf_q  <= 1'b0;
    end else begin
      if (rx_done) rxf_q <= 1'b1;
      else if (data_rd && rx_arm_q) rxf_q <= 1'b0;
      if (load) txe_q <= 1'b1;
      else if (accept) txe_q <= 1'b0;
      if (mf_event) mf_q <= 1'b1;
      else if (c1_wr && mf_arm_q) mf_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts and pin drivers
  // ---------------------------------------------------------------------------
  logic [2:0] ev;  // event pulses
  assign ev = {mf_event, load, rx_done};

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_st_q <= IRQ_RST;
      irq_out  <= 1'b0;
    end else begin
      if (xfer && pwrite_in && (idx == IDX_IRQ_CLR)) begin
        irq_st_q <= (irq_st_q & ~pwdata_in[2:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      irq_out <= |(irq_st_q & irq_en_q);
    end
  end

  // drive lines only in the role that owns them
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
      mosi_out    <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      sclk_out    <= sck_q;
      sclk_oe_out <= enabled && master;
      mosi_out    <= shift_q[7];
      mosi_oe_out <= enabled && master;
      miso_out    <= shift_q[7];
      miso_oe_out <= enabled && !master && !ss_s2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_rx_armed;
    rxf_q && rx_arm_q && !rx_done;
  endsequence
  sequence s_rx_clear;
    s_rx_armed ##0 data_rd;
  endsequence

  a_rx_flag_set: assert property (rx_done |=> rxf_q)
    else $error("rx flag not set after byte received");
  a_rx_seq_clear: assert property (s_rx_clear |=> !rxf_q ##1 !rx_arm_q || rxf_q)
    else $error("rx flag not cleared by read sequence");
  a_rx_no_early: assert property (rxf_q && data_rd && !rx_arm_q |=> rxf_q)
    else $error("rx flag cleared without status read");
  a_tx_accept_data: assert property (accept |=> !txe_q && tx_buf_q == $past(pwdata_in[7:0]))
    else $error("armed data write not accepted");
  a_tx_write_ignored: assert property (data_wr && !tx_arm_q |=> $stable(tx_buf_q))
    else $error("unarmed data write changed buffer");
  a_fault_set: assert property (mf_event |=> mf_q)
    else $error("mode fault not flagged");
  a_fault_clear: assert property (c1_wr && mf_arm_q && !mf_event |=> !mf_q)
    else $error("fault flag not cleared by sequence");
  a_status_wr_none: assert property (xfer && pwrite_in && idx == IDX_STATUS && !rx_done
    && !load && !mf_event |=> $stable({rxf_q, txe_q, mf_q}))
    else $error("status write changed flags");
  a_arm_survives: assert property (tx_arm_q && xfer && !data_wr |=> tx_arm_q)
    else $error("tx sequence broken by unrelated access");
  a_irq_level: assert property (|(irq_st_q & irq_en_q) |=> irq_out)
    else $error("enabled event did not raise interrupt");

endmodule

//--- test/spibf_slave_model.sv
// behavioural slave device at the far end of the serial link
// assumes clock idle low, sample on rise, shift on fall, msb first
`timescale 1ns/1ps
module spibf_slave_model (
  input  wire logic       sclk_in,     // serial clock from the master
  input  wire logic       sclk_oe_in,  // master drives the clock
  input  wire logic       mosi_in,     // data from the master
  input  wire logic       load_in,     // rising edge loads the reply
  input  wire logic [7:0] reply_in,    // byte to send back
  output logic            miso_out,    // data to the master
  output logic [7:0]      got_out      // byte taken from the master
);
  logic [7:0] sh_q;  // outgoing shift register

  initial sh_q = 8'h00;
  initial got_out = 8'h00;
  // reply byte is parked until the master clocks it out
  always @(posedge load_in) sh_q <= reply_in;
  // shift on falling edges; the refill bit is junk on purpose
  always @(negedge sclk_in) sh_q <= {sh_q[6:0], ~sh_q[0]};
  // sample the master's data on rising edges
  always @(posedge sclk_in) got_out <= {got_out[6:0], mosi_in};
  // a released clock means nobody is talking: show the inverse
  assign miso_out = sclk_oe_in ? sh_q[7] : ~sh_q[7];
endmodule

//--- test/test_spi_baud_and_status_flags.sv
// self-checking bench for the spi baud and status-flag block
// assumes the slave model answers the link; registers at 4*index
`timescale 1ns/1ps
module test_spi_baud_and_status_flags
  import spibf_pkg::*;
();
  logic        clk, rst_n, psel, pen, pwr, slv_load, ss_n, last_err;  // bench drives
  logic [11:0] paddr;    // apb address
  logic [31:0] pwdata;   // apb write data
  logic [31:0] prdata;   // apb read data
  logic        pready, perr, sck, sck_oe, mosi, miso, irq, mosi_oe, miso_oe;  // block outputs, plus miso from the slave model
  logic [7:0]  reply, got;  // slave model bytes
  int          n_fail, n_tests;  // counters

  spibf_top u_dut (.clock_in(clk), .resetn_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .sclk_in(1'b0),
    .sclk_out(sck), .sclk_oe_out(sck_oe), .mosi_in(1'b0), .mosi_out(mosi),
    .mosi_oe_out(mosi_oe), .miso_in(miso), .miso_out(), .miso_oe_out(miso_oe), .ss_n_in(ss_n),
    .irq_out(irq));

  spibf_slave_model u_slv (.sclk_in(sck), .sclk_oe_in(sck_oe), .mosi_in(mosi),
    .load_in(slv_load), .reply_in(reply), .miso_out(miso), .got_out(got));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {6'h00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    last_err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, idx, d, v);
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] e);
    logic [31:0] v;
    apb(1'b0, idx, 32'h0, v);
    chk(v, e);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // data write with no status read first must not start a transfer
  task automatic t_ignore();
    wr(IDX_CTRL1, 32'h50);
    wr(IDX_DATA, 32'h77);
    repeat (40) @(posedge clk);
    rdc(IDX_STATUS, 32'h20);
    $display("test ignore done");
  endtask
  // status is read-only, unmapped index errors
  task automatic t_regs();
    wr(IDX_STATUS, 32'hff);
    rdc(IDX_STATUS, 32'h20);
    rdc(4'h4, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    // enabled master drives clock and mosi, leaves miso to the slave
    chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h6);
    $display("test regs done");
  endtask
  // one byte each way at a given divisor
  task automatic t_xfer(input logic [2:0] pre, input logic [2:0] rate,
                        input logic [7:0] tx, input logic [7:0] rx);
    int n, m0, k;
    logic [31:0] v;
    n = 0;
    m0 = 0;
    wr(IDX_BAUD, {25'h0, pre, 1'b0, rate});
    wr(IDX_IRQ_CLR, 32'h1);
    reply <= rx;
    slv_load <= 1'b1;
    @(posedge clk);
    slv_load <= 1'b0;
    rdc(IDX_STATUS, 32'h20);
    wr(IDX_DATA, {24'h0, tx});
    // measure the span between two clock rises
    for (k = 0; k < 2; k++) begin
      while (sck !== 1'b0 && n < 9000) begin
        @(posedge clk);
        n++;
      end
      while (sck !== 1'b1 && n < 9000) begin
        @(posedge clk);
        n++;
      end
      if (k == 0) m0 = n;
    end
    chk(32'(n - m0), 32'((int'(pre) + 1) << (int'(rate) + 1)));
    k = 0;
    // wait on the event bit so that the first data read is not armed
    do begin
      apb(1'b0, IDX_IRQ_ST, 32'h0, v);
      k++;
    end while (v[EV_RX] !== 1'b1 && k < 4000);
    rdc(IDX_DATA, {24'h0, rx});
    rdc(IDX_STATUS, 32'ha0);
    rdc(IDX_BAUD, {25'h0, pre, 1'b0, rate});
    rdc(IDX_DATA, {24'h0, rx});
    rdc(IDX_STATUS, 32'h20);
    chk({24'h0, got}, {24'h0, tx});
    $display("test xfer done");
  endtask
  // mode fault set, clear and interrupt
  task automatic t_fault();
    rdc(IDX_IRQ_ST, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_CLR, 32'h7);
    wr(IDX_IRQ_EN, 32'h4);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(IDX_STATUS, 32'h20);
    ss_n <= 1'b1;
    wr(IDX_CTRL2, 32'h10);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(IDX_STATUS, 32'h30);
    chk({31'h0, irq}, 32'h1);
    ss_n <= 1'b1;
    rdc(IDX_IRQ_ST, 32'h4);
    wr(IDX_CTRL1, 32'h50);
    rdc(IDX_STATUS, 32'h20);
    wr(IDX_IRQ_CLR, 32'h4);
    rdc(IDX_IRQ_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test fault done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cuts a hang well past the longest transfer
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
  initial begin
    {rst_n, psel, pen, pwr, slv_load, last_err} = 6'h00;
    ss_n = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    reply = 8'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_ignore();
    t_regs();
    // divisor 2 leaves no room for the miso sync lag: only a constant reply
    t_xfer(3'h0, 3'h0, 8'ha5, 8'hff);
    t_xfer(3'h2, 3'h1, 8'h81, 8'h7e);
    t_xfer(3'h3, 3'h7, 8'h5a, 8'hc3);
    t_fault();
    summarize();
  end
endmodule
